// file: rtl/ncorc_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module ncorc_fifo #(
   parameter  int WIDTH = 32,
   parameter  int DEPTH = 8,
   localparam int AW    = $clog2(DEPTH),
   localparam int CW    = $clog2(DEPTH + 1)
) (
   // clock and reset
   input  wire logic             ref_clk,
   input  wire logic             rst_b,
   // fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data,
   // fill level
   output logic [CW-1:0]         count
);

   if (DEPTH < 2) begin : g_bad_depth
      $error("fifo depth below two");
   end

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [WIDTH-1:0] mem_d [DEPTH];
   logic [AW-1:0]    wr_q;
   logic [AW-1:0]    wr_d;
   logic [AW-1:0]    rd_q;
   logic [AW-1:0]    rd_d;
   logic [CW-1:0]    cnt_q;
   logic [CW-1:0]    cnt_d;
   logic             push;
   logic             pop;

   assign in_ready  = (cnt_q != CW'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign out_data  = mem_q[rd_q];
   assign count     = cnt_q;
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   // pointer wrap and occupancy
   always_comb begin
      mem_d = mem_q;
      wr_d  = wr_q;
      rd_d  = rd_q;
      cnt_d = cnt_q;
      if (push) begin
         mem_d[wr_q] = in_data;
         wr_d        = (wr_q == AW'(DEPTH - 1)) ? '0 : AW'(wr_q + 1'b1);
      end
      if (pop) begin
         rd_d = (rd_q == AW'(DEPTH - 1)) ? '0 : AW'(rd_q + 1'b1);
      end
      if (push && !pop) begin
         cnt_d = CW'(cnt_q + 1'b1);
      end else if (pop && !push) begin
         cnt_d = CW'(cnt_q - 1'b1);
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         mem_q <= '{default: '0};
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else begin
         mem_q <= mem_d;
         wr_q  <= wr_d;
         rd_q  <= rd_d;
         cnt_q <= cnt_d;
      end
   end

endmodule // ncorc_fifo
`default_nettype wire

// file: rtl/ncorc_lfsr.sv
`timescale 1ns/10ps
`default_nettype none
module ncorc_lfsr
   import ncorc_pkg::*;
#(
   parameter int                WIDTH = LFSR_W,
   parameter logic [WIDTH-1:0]  TAPS  = LFSR_TAPS,
   parameter logic [WIDTH-1:0]  SEED  = LFSR_SEED
) (
   // clock and reset
   input  wire logic             ref_clk,
   input  wire logic             rst_b,
   // random word
   output logic [WIDTH-1:0]      state
);

   logic [WIDTH-1:0] lfsr_q;
   logic [WIDTH-1:0] lfsr_d;

   // galois shift, one step per clock
   always_comb begin
      lfsr_d = {1'b0, lfsr_q[WIDTH-1:1]};
      if (lfsr_q[0]) begin
         lfsr_d = lfsr_d ^ TAPS;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         lfsr_q <= SEED;
      end else begin
         lfsr_q <= lfsr_d;
      end
   end

   assign state = lfsr_q;

endmodule // ncorc_lfsr
`default_nettype wire

// file: rtl/ncorc_pkg.sv
package ncorc_pkg;

   // register offsets
   localparam logic [7:0] ADDR_HOLDOFF   = 8'h84;
   localparam logic [7:0] ADDR_FREQ_LO   = 8'h85;
   localparam logic [7:0] ADDR_FREQ_HI   = 8'h86;
   localparam logic [7:0] ADDR_PHASE_OFS = 8'h87;
   localparam logic [7:0] ADDR_CTRL      = 8'h88;
   localparam logic [7:0] ADDR_DECIM     = 8'h90;
   localparam logic [7:0] ADDR_INTERP    = 8'h91;
   localparam logic [7:0] ADDR_SCALE     = 8'h92;

   // widths
   localparam int REG_W       = 16;
   localparam int ADC_W       = 12;
   localparam int MIX_W       = 16;
   localparam int ACC_W       = 48;
   localparam int FRAC_W      = 24;
   localparam int DECIM_W     = 12;
   localparam int INTERP_W    = 9;
   localparam int RATE_W      = 13;
   localparam int SCALE_W     = 5;
   localparam int HOLD_W      = 16;
   localparam int FREQ_W      = 32;
   localparam int OFS_W       = 16;
   localparam int PIDX_W      = 6;
   localparam int AMP_W       = 9;
   localparam int DITH_W      = 10;
   localparam int LFSR_W      = 16;
   localparam int CTRL_W      = 9;
   localparam int SCALE_REG_W = 10;
   localparam int PROD_W      = ADC_W + AMP_W;

   // datapath slicing
   localparam int MIX_LSB     = 3;
   localparam int BYP_PAD     = MIX_W - ADC_W;
   localparam int FIFO_MARGIN = 4;

   // misc values
   localparam logic [HOLD_W-1:0] HOLD_ONE  = 16'h0001;
   localparam logic [LFSR_W-1:0] LFSR_TAPS = 16'hB400;
   localparam logic [LFSR_W-1:0] LFSR_SEED = 16'hACE1;
   localparam logic [1:0]        SYNC_A    = 2'h0;
   localparam logic [1:0]        SYNC_B    = 2'h1;
   localparam logic [1:0]        SYNC_C    = 2'h2;
   localparam logic [1:0]        SYNC_D    = 2'h3;

   typedef struct packed {
      logic [1:0] sync_sel;
      logic       in_sel;
      logic [1:0] rsvd;
      logic       clr_hop;
      logic       amp_dith;
      logic       ph_dith;
      logic       bypass;
   } ncorc_ctrl_s;

   typedef struct packed {
      logic [SCALE_W-1:0] scale_when_line_idle;
      logic [SCALE_W-1:0] scale_when_line_active;
   } ncorc_scale_s;

   typedef struct packed {
      logic signed [MIX_W-1:0] q;
      logic signed [MIX_W-1:0] i;
   } ncorc_iq_s;

   typedef enum logic [1:0] {
      HOP_IDLE = 2'b01,
      HOP_WAIT = 2'b10
   } ncorc_hop_e;

endpackage

// file: rtl/ncorc_top.sv
`timescale 1ns/10ps
`default_nettype none
module ncorc_top
   import ncorc_pkg::*;
#(
   parameter logic [1:0] CHAN_ID    = 2'h0,
   parameter int         FIFO_DEPTH = 8
) (
   // clock and reset
   input  wire logic             ref_clk,
   input  wire logic             rst_b,
   // register port
   input  wire logic             reg_wr,
   input  wire logic             reg_rd,
   input  wire logic [1:0]       reg_chan,
   input  wire logic [7:0]       reg_addr,
   input  wire logic [REG_W-1:0] reg_wdata,
   output logic [REG_W-1:0]      reg_rdata,
   // sample input ports
   input  wire logic             samp_valid,
   output logic                  samp_ready,
   input  wire logic [ADC_W-1:0] port_a_data,
   input  wire logic [ADC_W-1:0] port_b_data,
   // channel status
   input  wire logic             chan_sleep,
   input  wire logic             gain_switch_line,
   // external sync pins
   input  wire logic             sync_pin_a,
   input  wire logic             sync_pin_b,
   input  wire logic             sync_pin_c,
   input  wire logic             sync_pin_d,
   // filtered output
   output logic                  out_valid,
   input  wire logic             out_ready,
   output ncorc_iq_s             out_data
);

   localparam int CNT_W = $clog2(FIFO_DEPTH + 1);

   if (FIFO_DEPTH < FIFO_MARGIN + 1) begin : g_bad_depth
      $error("fifo depth too small for pipeline");
   end

   // register file
   ncorc_ctrl_s          ctrl_q, ctrl_d;
   ncorc_scale_s         scale_q, scale_d;
   logic [DECIM_W-1:0]   decim_q, decim_d;
   logic [INTERP_W-1:0]  interp_q, interp_d;
   logic [HOLD_W-1:0]    holdoff_q, holdoff_d;
   logic [FREQ_W-1:0]    shadow_q, shadow_d;
   logic [OFS_W-1:0]     ofs_q, ofs_d;
   logic [REG_W-1:0]     rdata_q, rdata_d;
   logic                 reg_hit;
   logic                 rate_wr;
   // hop control
   logic [3:0]           sync1_q, sync2_q;
   logic                 sel_lvl_q, sel_lvl_d;
   logic                 sleep_prev_q;
   ncorc_hop_e           hop_q, hop_d;
   logic [HOLD_W-1:0]    cnt_q, cnt_d;
   logic [FREQ_W-1:0]    active_q, active_d;
   logic                 trig;
   logic                 freq_load;
   // oscillator and mixer
   logic [FREQ_W-1:0]    acc_q, acc_d;
   ncorc_iq_s            mix_q, mix_d;
   logic                 mix_vld_q, mix_vld_d;
   logic [LFSR_W-1:0]    rnd;
   logic                 take;
   logic [OFS_W-1:0]     ph_word;
   logic [ADC_W-1:0]     x_sel;
   logic signed [PROD_W-1:0] prod_c, prod_s;
   // resampler
   logic signed [ACC_W-1:0] i1_q [2], i1_d [2], i2_q [2], i2_d [2];
   logic signed [ACC_W-1:0] d1_q [2], d1_d [2], d2_q [2], d2_d [2];
   logic signed [ACC_W-1:0] xs [2], i1n [2], i2o [2], c1 [2], c2 [2];
   logic [RATE_W-1:0]    ph_q, ph_d;
   logic [RATE_W-1:0]    lfac, mfac, lsum, step;
   logic [SCALE_W-1:0]   s_now;
   logic                 hit;
   ncorc_iq_s            res_q, res_d;
   logic                 res_vld_q, res_vld_d;
   // output side
   logic                 fifo_in_ready;
   logic                 fifo_vld;
   ncorc_iq_s            fifo_data;
   logic [CNT_W-1:0]     fifo_cnt;
   logic                 fifo_pop;
   logic                 out_vld_q, out_vld_d;
   ncorc_iq_s            out_q, out_d;
   logic                 rdy_q, rdy_d;

   // sine of six-bit phase from quarter-wave table
   function automatic logic signed [AMP_W-1:0] sine_of(input logic [PIDX_W-1:0] idx, input logic dbit);
      logic [3:0]       a;
      logic [AMP_W-1:0] mag;
      a = idx[4] ? ~idx[3:0] : idx[3:0];
      case (a)
         4'h0: mag = 9'h006;  4'h1: mag = 9'h013;  4'h2: mag = 9'h01F;  4'h3: mag = 9'h02B;
         4'h4: mag = 9'h036;  4'h5: mag = 9'h041;  4'h6: mag = 9'h04C;  4'h7: mag = 9'h055;
         4'h8: mag = 9'h05E;  4'h9: mag = 9'h066;  4'hA: mag = 9'h06D;  4'hB: mag = 9'h073;
         4'hC: mag = 9'h078;  4'hD: mag = 9'h07B;  4'hE: mag = 9'h07E;  default: mag = 9'h07F;
      endcase
      mag = mag + AMP_W'(dbit);
      return idx[5] ? -$signed(mag) : $signed(mag);
   endfunction

   // register access
   assign reg_hit = (reg_chan == CHAN_ID);

   always_comb begin
      ctrl_d    = ctrl_q;
      scale_d   = scale_q;
      decim_d   = decim_q;
      interp_d  = interp_q;
      holdoff_d = holdoff_q;
      shadow_d  = shadow_q;
      ofs_d     = ofs_q;
      rdata_d   = rdata_q;
      rate_wr   = 1'b0;
      if (reg_hit && reg_wr) begin
         case (reg_addr)
            ADDR_HOLDOFF:   holdoff_d = reg_wdata;
            ADDR_FREQ_LO:   shadow_d[REG_W-1:0] = reg_wdata;
            ADDR_FREQ_HI:   shadow_d[FREQ_W-1:REG_W] = reg_wdata;
            ADDR_PHASE_OFS: ofs_d = reg_wdata;
            ADDR_CTRL: begin
               ctrl_d      = ncorc_ctrl_s'(reg_wdata[CTRL_W-1:0]);
               ctrl_d.rsvd = 2'h0;
            end
            ADDR_DECIM: begin
               decim_d = reg_wdata[DECIM_W-1:0];
               rate_wr = 1'b1;
            end
            ADDR_INTERP: begin
               interp_d = reg_wdata[INTERP_W-1:0];
               rate_wr  = 1'b1;
            end
            ADDR_SCALE:     scale_d = ncorc_scale_s'(reg_wdata[SCALE_REG_W-1:0]);
            default: ;
         endcase
      end
      if (reg_hit && reg_rd) begin
         case (reg_addr)
            ADDR_HOLDOFF:   rdata_d = holdoff_q;
            ADDR_FREQ_LO:   rdata_d = active_q[REG_W-1:0];
            ADDR_FREQ_HI:   rdata_d = active_q[FREQ_W-1:REG_W];
            ADDR_PHASE_OFS: rdata_d = ofs_q;
            ADDR_CTRL:      rdata_d = REG_W'(ctrl_q);
            ADDR_DECIM:     rdata_d = REG_W'(decim_q);
            ADDR_INTERP:    rdata_d = REG_W'(interp_q);
            ADDR_SCALE:     rdata_d = REG_W'(scale_q);
            default:        rdata_d = '0;
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl_q    <= '0;
         scale_q   <= '0;
         decim_q   <= '0;
         interp_q  <= '0;
         holdoff_q <= '0;
         shadow_q  <= '0;
         ofs_q     <= '0;
         rdata_q   <= '0;
      end else begin
         ctrl_q    <= ctrl_d;
         scale_q   <= scale_d;
         decim_q   <= decim_d;
         interp_q  <= interp_d;
         holdoff_q <= holdoff_d;
         shadow_q  <= shadow_d;
         ofs_q     <= ofs_d;
         rdata_q   <= rdata_d;
      end
   end

   // sync pick, wake detect and frequency hold-off
   assign sel_lvl_d = sync2_q[ctrl_q.sync_sel];
   assign trig      = (sel_lvl_d & ~sel_lvl_q) | (sleep_prev_q & ~chan_sleep);

   always_comb begin
      hop_d     = hop_q;
      cnt_d     = cnt_q;
      active_d  = active_q;
      freq_load = 1'b0;
      case (hop_q)
         HOP_IDLE: begin
            if (trig && holdoff_q != '0) begin
               cnt_d = holdoff_q;
               hop_d = HOP_WAIT;
            end
         end
         HOP_WAIT: begin
            if (trig) begin
               cnt_d = holdoff_q;
               hop_d = (holdoff_q != '0) ? HOP_WAIT : HOP_IDLE;
            end else if (cnt_q == HOLD_ONE) begin
               active_d  = shadow_q;
               freq_load = 1'b1;
               hop_d     = HOP_IDLE;
            end else begin
               cnt_d = cnt_q - HOLD_ONE;
            end
         end
         default: hop_d = HOP_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         sync1_q      <= '0;
         sync2_q      <= '0;
         sel_lvl_q    <= 1'b0;
         sleep_prev_q <= 1'b0;
         hop_q        <= HOP_IDLE;
         cnt_q        <= '0;
         active_q     <= '0;
      end else begin
         sync1_q      <= {sync_pin_d, sync_pin_c, sync_pin_b, sync_pin_a};
         sync2_q      <= sync1_q;
         sel_lvl_q    <= sel_lvl_d;
         sleep_prev_q <= chan_sleep;
         hop_q        <= hop_d;
         cnt_q        <= cnt_d;
         active_q     <= active_d;
      end
   end

   // oscillator and mixer
   ncorc_lfsr u_lfsr (
      .ref_clk (ref_clk),
      .rst_b   (rst_b),
      .state   (rnd)
   );

   assign take    = samp_valid & rdy_q & ~chan_sleep;
   assign x_sel   = ctrl_q.in_sel ? port_b_data : port_a_data;
   assign ph_word = acc_q[FREQ_W-1:FREQ_W-OFS_W] + ofs_q
                  + (ctrl_q.ph_dith ? OFS_W'(rnd[DITH_W-1:0]) : '0);
   assign prod_c  = $signed(x_sel) * sine_of(ph_word[OFS_W-1:OFS_W-PIDX_W] + PIDX_W'(16),
                                             ctrl_q.amp_dith & rnd[DITH_W]);
   assign prod_s  = $signed(x_sel) * -sine_of(ph_word[OFS_W-1:OFS_W-PIDX_W],
                                              ctrl_q.amp_dith & rnd[DITH_W+1]);

   always_comb begin
      acc_d     = acc_q;
      mix_d     = mix_q;
      mix_vld_d = take;
      if (freq_load && ctrl_q.clr_hop) begin
         acc_d = '0;
      end else if (take) begin
         acc_d = acc_q + active_q;
      end
      if (take) begin
         if (ctrl_q.bypass) begin
            mix_d.i = {port_a_data, BYP_PAD'(0)};
            mix_d.q = {port_b_data, BYP_PAD'(0)};
         end else begin
            mix_d.i = prod_c[MIX_LSB +: MIX_W];
            mix_d.q = prod_s[MIX_LSB +: MIX_W];
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         acc_q     <= '0;
         mix_q     <= '0;
         mix_vld_q <= 1'b0;
      end else begin
         acc_q     <= acc_d;
         mix_q     <= mix_d;
         mix_vld_q <= mix_vld_d;
      end
   end

   // resampler: L virtual steps per input folded into one clock
   assign lfac  = RATE_W'(interp_q) + RATE_W'(1);
   assign mfac  = RATE_W'(decim_q) + RATE_W'(1);
   assign lsum  = ph_q + lfac;
   assign hit   = (lsum >= mfac);
   assign step  = mfac - ph_q;
   assign s_now = gain_switch_line ? scale_q.scale_when_line_active
                                   : scale_q.scale_when_line_idle;

   always_comb begin
      ph_d      = ph_q;
      res_d     = res_q;
      res_vld_d = mix_vld_q & hit;
      for (int l = 0; l < 2; l++) begin
         xs[l]  = $signed({{(ACC_W - MIX_W - FRAC_W){(l == 0) ? mix_q.i[MIX_W-1] : mix_q.q[MIX_W-1]}},
                           (l == 0) ? mix_q.i : mix_q.q, FRAC_W'(0)}) >>> s_now;
         i1n[l] = i1_q[l] + xs[l];
         i2o[l] = ACC_W'(i2_q[l] + i1n[l] * $signed({1'b0, step}));
         c1[l]  = i2o[l] - d1_q[l];
         c2[l]  = c1[l] - d2_q[l];
         i1_d[l] = i1_q[l];
         i2_d[l] = i2_q[l];
         d1_d[l] = d1_q[l];
         d2_d[l] = d2_q[l];
         if (mix_vld_q) begin
            i1_d[l] = i1n[l];
            i2_d[l] = ACC_W'(i2_q[l] + i1n[l] * $signed({1'b0, lfac}));
            if (hit) begin
               d1_d[l] = i2o[l];
               d2_d[l] = c1[l];
            end
         end
         if (rate_wr) begin
            i1_d[l] = '0;
            i2_d[l] = '0;
            d1_d[l] = '0;
            d2_d[l] = '0;
         end
      end
      if (mix_vld_q && hit) begin
         res_d.i = c2[0][FRAC_W +: MIX_W];
         res_d.q = c2[1][FRAC_W +: MIX_W];
      end
      if (mix_vld_q) begin
         ph_d = hit ? RATE_W'(lsum - mfac) : lsum;
      end
      if (rate_wr) begin
         ph_d      = '0;
         res_vld_d = 1'b0;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         i1_q      <= '{default: '0};
         i2_q      <= '{default: '0};
         d1_q      <= '{default: '0};
         d2_q      <= '{default: '0};
         ph_q      <= '0;
         res_q     <= '0;
         res_vld_q <= 1'b0;
      end else begin
         i1_q      <= i1_d;
         i2_q      <= i2_d;
         d1_q      <= d1_d;
         d2_q      <= d2_d;
         ph_q      <= ph_d;
         res_q     <= res_d;
         res_vld_q <= res_vld_d;
      end
   end

   // output buffer and registered head
   ncorc_fifo #(
      .WIDTH (2 * MIX_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .ref_clk   (ref_clk),
      .rst_b     (rst_b),
      .in_valid  (res_vld_q),
      .in_ready  (fifo_in_ready),
      .in_data   (res_q),
      .out_valid (fifo_vld),
      .out_ready (fifo_pop),
      .out_data  (fifo_data),
      .count     (fifo_cnt)
   );

   assign fifo_pop = !out_vld_q || out_ready;

   always_comb begin
      out_vld_d = out_vld_q;
      out_d     = out_q;
      if (fifo_pop) begin
         out_vld_d = fifo_vld;
         out_d     = fifo_vld ? fifo_data : out_q;
      end
      rdy_d = (fifo_cnt <= CNT_W'(FIFO_DEPTH - FIFO_MARGIN)) & fifo_in_ready & ~chan_sleep;
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         out_vld_q <= 1'b0;
         out_q     <= '0;
         rdy_q     <= 1'b0;
      end else begin
         out_vld_q <= out_vld_d;
         out_q     <= out_d;
         rdy_q     <= rdy_d;
      end
   end

   assign reg_rdata  = rdata_q;
   assign samp_ready = rdy_q;
   assign out_valid  = out_vld_q;
   assign out_data   = out_q;

endmodule // ncorc_top
`default_nettype wire

// file: verif/nco_control_resampling_cic_test.sv
`timescale 1ns/10ps
`default_nettype none
module nco_control_resampling_cic_test
   import ncorc_pkg::*;
;
   logic        ref_clk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, samp_valid = 0;
   logic        chan_sleep = 0, gain_switch_line = 0, hold = 0, slow = 0;
   logic        samp_ready, out_valid, out_ready;
   logic [1:0]  reg_chan = 0;
   logic [7:0]  reg_addr = 0;
   logic [15:0] reg_wdata = 0, reg_rdata;
   logic [11:0] port_a_data = 0, port_b_data = 0;
   logic [3:0]  sync = 0;
   ncorc_iq_s   out_data;
   int          fail_count = 0, n_tests = 0, seed = 78594;
   int          n_in = 0, n_out = 0, sh, ai, bi, e, sc_idle = 0, sc_act = 0;
   bit          cmp_on = 1, mix_on = 0;
   logic [31:0] q[$];
   logic [7:0]  ra[6] = '{ADDR_CTRL, ADDR_SCALE, ADDR_DECIM, ADDR_INTERP, ADDR_HOLDOFF, ADDR_PHASE_OFS};
   logic [15:0] rm[6] = '{16'h01CF, 16'h03FF, 16'h0FFF, 16'h01FF, 16'hFFFF, 16'hFFFF};
   int          sv[3] = '{0, 3, 31};
   int          lm[4][2] = '{'{1, 4}, '{3, 4}, '{2, 7}, '{512, 4096}};
   initial forever #12.5 ref_clk = ~ref_clk;
   ncorc_top #(.CHAN_ID(2'h0), .FIFO_DEPTH(8)) dut (
      .ref_clk, .rst_b, .reg_wr, .reg_rd, .reg_chan, .reg_addr, .reg_wdata, .reg_rdata,
      .samp_valid, .samp_ready, .port_a_data, .port_b_data, .chan_sleep, .gain_switch_line,
      .sync_pin_a(sync[0]), .sync_pin_b(sync[1]), .sync_pin_c(sync[2]), .sync_pin_d(sync[3]),
      .out_valid, .out_ready, .out_data);
   ncorc_sink_model u_sink (.ref_clk, .rst_b, .hold, .slow, .out_ready);
   // reference model of taken samples
   always @(posedge ref_clk) begin
      if (rst_b && samp_valid && samp_ready && !chan_sleep) begin
         n_in++;
         sh = gain_switch_line ? sc_act : sc_idle;
         ai = int'($signed(port_a_data)) * 16;
         bi = int'($signed(port_b_data)) * 16;
         q.push_back(mix_on ? 32'h0 : {16'(bi >>> sh), 16'(ai >>> sh)});
      end
      if (rst_b && out_valid && out_ready) begin
         n_out++;
         if (cmp_on) chk(out_data, q.pop_front());
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] c = 2'h0);
      @(posedge ref_clk);
      reg_wr    <= 1'h1;
      reg_chan  <= c;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'h0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [15:0] x);
      @(posedge ref_clk);
      reg_rd   <= 1'h1;
      reg_chan <= 2'h0;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'h0;
      #1 chk(32'(reg_rdata), 32'(x));
   endtask
   task automatic feed(input int n, input logic [11:0] bm = 12'hFFF);
      repeat (n) begin
         @(posedge ref_clk);
         samp_valid  <= 1'h1;
         port_a_data <= 12'($random(seed));
         port_b_data <= 12'($random(seed)) & bm;
      end
      @(posedge ref_clk);
      samp_valid <= 1'h0;
   endtask
   task automatic pulse(input int k);
      @(posedge ref_clk);
      sync <= 4'(1 << k);
      repeat (3) @(posedge ref_clk);
      sync <= 4'h0;
      repeat (8) @(posedge ref_clk);
   endtask
   task automatic summarize;
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   initial begin
      #500000;
      fail_count++;
      summarize();
   end
   initial begin
      repeat (5) @(posedge ref_clk);
      rst_b <= 1'h1;
      foreach (ra[i]) begin
         wr(ra[i], rm[i]);
         rd(ra[i], rm[i]);
      end
      rd(8'h00, 16'h0000);
      wr(ADDR_CTRL, 16'h0000, 2'h1);
      rd(ADDR_CTRL, 16'h01CF);
      wr(ADDR_HOLDOFF, 16'h0003);
      for (int p = 0; p < 4; p++) begin
         wr(ADDR_CTRL, 16'(p << 7));
         wr(ADDR_FREQ_LO, 16'(p + 1));
         pulse((p + 1) % 4);
         rd(ADDR_FREQ_LO, 16'(p));
         pulse(p);
         rd(ADDR_FREQ_LO, 16'(p + 1));
      end
      wr(ADDR_CTRL, 16'h0001);
      wr(ADDR_DECIM, 16'h0000);
      wr(ADDR_INTERP, 16'h0000);
      slow <= 1'h1;
      foreach (sv[i]) begin
         sc_idle = sv[i];
         wr(ADDR_SCALE, 16'({sv[i][4:0], sv[i][4:0]}));
         feed(20);
         repeat (60) @(posedge ref_clk);
      end
      sc_idle = 2;
      sc_act = 6;
      wr(ADDR_SCALE, 16'h0046);
      gain_switch_line <= 1'h1;
      feed(20);
      repeat (60) @(posedge ref_clk);
      gain_switch_line <= 1'h0;
      hold <= 1'h1;
      feed(12);
      #1 chk(32'(samp_ready), 32'h0);
      hold <= 1'h0;
      repeat (60) @(posedge ref_clk);
      chk(32'(n_out), 32'(n_in));
      wr(ADDR_CTRL, 16'h0046);
      mix_on = 1;
      feed(20, 12'h000);
      repeat (60) @(posedge ref_clk);
      mix_on = 0;
      cmp_on = 0;
      foreach (lm[i]) begin
         wr(ADDR_DECIM, 16'(lm[i][1] - 1));
         wr(ADDR_INTERP, 16'(lm[i][0] - 1));
         n_in = 0;
         n_out = 0;
         feed(48);
         repeat (60) @(posedge ref_clk);
         e = n_in * lm[i][0] / lm[i][1];
         chk(32'(n_out >= e - 1 && n_out <= e + 1), 32'h1);
      end
      chan_sleep <= 1'h1;
      n_in = 0;
      feed(5);
      chk(32'(n_in), 32'h0);
      summarize();
   end
endmodule // nco_control_resampling_cic_test
`default_nettype wire

// file: verif/ncorc_properties.sv
`timescale 1ns/10ps
`default_nettype none
module ncorc_properties
   import ncorc_pkg::*;
#(
   parameter logic [1:0] CHAN_ID    = 2'h0,
   parameter int         FIFO_DEPTH = 8
) (
   // clock and reset
   input wire logic             ref_clk,
   input wire logic             rst_b,
   // register port
   input wire logic             reg_wr,
   input wire logic             reg_rd,
   input wire logic [1:0]       reg_chan,
   input wire logic [7:0]       reg_addr,
   input wire logic [REG_W-1:0] reg_wdata,
   input wire logic [REG_W-1:0] reg_rdata,
   // samples
   input wire logic             samp_valid,
   input wire logic             samp_ready,
   input wire logic             chan_sleep,
   input wire logic             out_valid,
   input wire logic             out_ready,
   input wire ncorc_iq_s        out_data
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   logic        me;
   logic [15:0] n_in_q, n_in_d, n_out_q, n_out_d;
   assign me = reg_chan == CHAN_ID;
   // taken and delivered counts
   always_comb begin
      n_in_d  = n_in_q + 16'(samp_valid & samp_ready & ~chan_sleep);
      n_out_d = n_out_q + 16'(out_valid & out_ready);
   end
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         n_in_q  <= 16'h0;
         n_out_q <= 16'h0;
      end else begin
         n_in_q  <= n_in_d;
         n_out_q <= n_out_d;
      end
   end
   property rb_p(a, m);
      reg_wr && me && reg_addr == a ##1 !reg_wr ##1 reg_rd && me && reg_addr == a
         |=> reg_rdata == (m & $past(reg_wdata, 3));
   endproperty
   out_hold_a: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data))
      else $error("output changed while stalled");
   sleep_refuse_a: assert property (chan_sleep |=> !samp_ready)
      else $error("ready while asleep");
   rdata_hold_a: assert property (!(reg_rd && me) |=> $stable(reg_rdata))
      else $error("read data moved without read");
   unmapped_zero_a: assert property (reg_rd && me && !(reg_addr inside {[8'h84:8'h88], [8'h90:8'h92]})
      |=> reg_rdata == 16'h0) else $error("unmapped read not zero");
   ctrl_readback_a: assert property (rb_p(ADDR_CTRL, 16'h01CF))
      else $error("control readback wrong");
   scale_readback_a: assert property (rb_p(ADDR_SCALE, 16'h03FF))
      else $error("scale readback wrong");
   decim_readback_a: assert property (rb_p(ADDR_DECIM, 16'h0FFF))
      else $error("decimation readback wrong");
   outs_bounded_a: assert property (n_out_q <= n_in_q)
      else $error("more outputs than inputs");
   cover property (out_valid && !out_ready ##1 out_valid && out_ready);
   cover property (samp_valid && !samp_ready && !chan_sleep);
   cover property (reg_rd && me && reg_addr == ADDR_FREQ_LO);
endmodule // ncorc_properties
bind ncorc_top ncorc_properties #(.CHAN_ID(CHAN_ID), .FIFO_DEPTH(FIFO_DEPTH)) u_props (
   .ref_clk, .rst_b, .reg_wr, .reg_rd, .reg_chan, .reg_addr, .reg_wdata, .reg_rdata,
   .samp_valid, .samp_ready, .chan_sleep, .out_valid, .out_ready, .out_data);
`default_nettype wire

// file: verif/ncorc_sink_model.sv
`timescale 1ns/10ps
`default_nettype none
module ncorc_sink_model (
   // clock and reset
   input  wire logic ref_clk,
   input  wire logic rst_b,
   // stall control
   input  wire logic hold,
   input  wire logic slow,
   // downstream accept
   output logic      out_ready
);
   int s = 78594;
   // prompt or randomly stalling acceptor
   always @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         out_ready <= 1'h0;
      end else begin
         out_ready <= !hold && (!slow || $random(s) % 3 != 0);
      end
   end
endmodule // ncorc_sink_model
`default_nettype wire
